// [lbr_loop_defines.vh]
// Constants for the local block-repeat loop controller
`ifndef LBR_LOOP_DEFINES_VH
`define LBR_LOOP_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LBR_OFS_CNT0      8'h00
`define LBR_OFS_CNT1      8'h04
`define LBR_OFS_SAVE1     8'h08
`define LBR_OFS_START0    8'h0C
`define LBR_OFS_END0      8'h10
`define LBR_OFS_START1    8'h14
`define LBR_OFS_END1      8'h18
`define LBR_OFS_CTRL      8'h1C
`define LBR_OFS_STATUS    8'h20
`define LBR_OFS_FLOWCTX   8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LBR_CTRL_LEGACY   0
`define LBR_CTRL_REPEAT_ACTIVE_FLAG     1
`define LBR_ST_ACT0       0
`define LBR_ST_ACT1       1
`define LBR_ST_FITERR     2
`define LBR_ST_CBTAKEN    3

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define LBR_RST_ZERO      32'h0000_0000
`define LBR_IBQ_BYTES     9'h080
`define LBR_CB_CYCLES     2'h3

`endif

// [lbr_loop_ctrl.v]
// Local block-repeat loop controller with APB register access
`timescale 1ns/1ns
`include "lbr_loop_defines.vh"

// Notes on behaviour
// - Level 0 runs count0 plus one times
// - Nested level runs save1 plus one times
// - Start0 loaded in address phase
// - End0 computed in address phase
// - Count0 decremented at last decode, nonzero
// - Count0 holds zero after loop ends
// - Save1 copied into count1 at repeat
// - Start1 and end1 loaded in address phase
// - Count1 decremented at last decode, nonzero
// - Save1 never changed by the loop
// - Body must fit aligned instruction queue
// - Local repeats may nest
// - Forward conditional branch takes three cycles
// - Legacy mode uses level 0 only
// - Legacy flag set on entry, cleared at end
// - Clearing legacy flag stops the loop
// - Flag captured on interrupt, cleared far
module lbr_loop_ctrl #(
    parameter AW = 24,
    parameter CW = 16
) (
    // Clock, reset, enable
    input  wire          i_ref_clk,
    input  wire          i_rst_n,
    input  wire          i_ce,
    // APB slave
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [7:0]    i_paddr,
    input  wire [31:0]   i_pwdata,
    output reg  [31:0]   o_prdata,
    output wire          o_pready,
    output wire          o_pslverr,
    // Address phase of the repeat instruction
    input  wire          i_ad_rpt,
    input  wire [AW-1:0] i_ad_first_addr,
    input  wire [7:0]    i_ad_body_bytes,
    input  wire [3:0]    i_ad_last_size,
    input  wire          i_ad_last_par,
    // Decode phase
    input  wire          i_dc_valid,
    input  wire [AW-1:0] i_dc_addr,
    // Forward conditional branch and condition
    input  wire          i_cb_req,
    input  wire          i_cond_set,
    input  wire          i_cond_val,
    // Control-flow events
    input  wire          i_exit_branch,
    input  wire          i_far_branch,
    input  wire          i_int_ack,
    // Fetch redirect and branch result
    output reg           o_redirect,
    output reg  [AW-1:0] o_redirect_addr,
    output reg           o_cb_done,
    output reg           o_cb_taken,
    output wire          o_cb_busy,
    output wire          o_loop_active,
    output wire          o_legacy_mode,
    output wire          o_flow_ctx_flag
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [CW-1:0] cnt0_q, cnt1_q, save1_q;
    reg [AW-1:0] start0_q, end0_q, start1_q, end1_q;
    reg          act0_q, act1_q, legacy_q, repeat_active_flag_q, fit_err_q, flow_ctx_q;
    reg          cond_q;
    reg [1:0]    cb_cnt_q;
    reg          cb_cond_q;

    // Zero-extend a count or address to 32-bit read data
    function [31:0] lbr_zext_cnt;
        input [CW-1:0] v;
        begin
            lbr_zext_cnt = {{(32-CW){1'b0}}, v};
        end
    endfunction

    function [31:0] lbr_zext_addr;
        input [AW-1:0] v;
        begin
            lbr_zext_addr = {{(32-AW){1'b0}}, v};
        end
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire wr_en   = i_psel & i_penable & i_pwrite;
    wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
    reg  hit;
    reg  [31:0] rd_mux;

    // Zero-wait slave
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;

    // Read data selection
    always @* begin
        hit    = 1'b1;
        rd_mux = `LBR_RST_ZERO;
        case (i_paddr)
            `LBR_OFS_CNT0:    rd_mux = lbr_zext_cnt(cnt0_q);
            `LBR_OFS_CNT1:    rd_mux = lbr_zext_cnt(cnt1_q);
            `LBR_OFS_SAVE1:   rd_mux = lbr_zext_cnt(save1_q);
            `LBR_OFS_START0:  rd_mux = lbr_zext_addr(start0_q);
            `LBR_OFS_END0:    rd_mux = lbr_zext_addr(end0_q);
            `LBR_OFS_START1:  rd_mux = lbr_zext_addr(start1_q);
            `LBR_OFS_END1:    rd_mux = lbr_zext_addr(end1_q);
            `LBR_OFS_CTRL:    rd_mux = {30'h0000_0000, repeat_active_flag_q, legacy_q};
            `LBR_OFS_STATUS:  rd_mux = {28'h000_0000, o_cb_taken, fit_err_q, act1_q, act0_q};
            `LBR_OFS_FLOWCTX: rd_mux = {31'h0000_0000, flow_ctx_q};
            default:          hit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Loop event decode
    // ----------------------------------------
    wire          sw_clr_repeat_active_flag = wr_en & (i_paddr == `LBR_OFS_CTRL) & ~i_pwdata[`LBR_CTRL_REPEAT_ACTIVE_FLAG];
    wire          nest1    = i_ad_rpt & act0_q & ~act1_q & ~legacy_q;
    wire          enter0   = i_ad_rpt & ~nest1 & (~act0_q | legacy_q);
    wire          end1_hit = i_dc_valid & act1_q & (i_dc_addr == end1_q);
    wire          end0_hit = i_dc_valid & act0_q & ~end1_hit & (i_dc_addr == end0_q);
    wire [AW-1:0] ad_end   = i_ad_first_addr + {{(AW-8){1'b0}}, i_ad_body_bytes}
                             - {{(AW-4){1'b0}}, i_ad_last_size};
    wire [8:0]    fit_sum  = {7'h00, i_ad_first_addr[1:0]} + {1'b0, i_ad_body_bytes};
    wire          fit_bad  = i_ad_rpt & ((fit_sum > `LBR_IBQ_BYTES) |
                             ((fit_sum == `LBR_IBQ_BYTES) & ~i_ad_last_par));

    assign o_loop_active  = act0_q | act1_q;
    assign o_legacy_mode  = legacy_q;
    assign o_flow_ctx_flag = flow_ctx_q;
    assign o_cb_busy      = (cb_cnt_q != 2'h0);

    // ----------------------------------------
    // APB read data register
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_prdata <= `LBR_RST_ZERO;
        end else if (i_ce && rd_setup) begin
            o_prdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Level 0 loop state
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt0_q   <= {CW{1'b0}};
            start0_q <= {AW{1'b0}};
            end0_q   <= {AW{1'b0}};
            act0_q   <= 1'b0;
        end else if (i_ce) begin
            // Software writes, overridden by loop events below
            if (wr_en && i_paddr == `LBR_OFS_CNT0) cnt0_q <= i_pwdata[CW-1:0];
            if (wr_en && i_paddr == `LBR_OFS_START0) start0_q <= i_pwdata[AW-1:0];
            if (wr_en && i_paddr == `LBR_OFS_END0) end0_q <= i_pwdata[AW-1:0];
            if (enter0) begin
                act0_q   <= 1'b1;
                start0_q <= i_ad_first_addr;
                end0_q   <= ad_end;
            end else if (end0_hit) begin
                if (cnt0_q != {CW{1'b0}}) begin
                    cnt0_q <= cnt0_q - {{(CW-1){1'b0}}, 1'b1};
                end else begin
                    act0_q <= 1'b0;
                end
            end else if (i_exit_branch && !act1_q) begin
                act0_q <= 1'b0;
            end else if (legacy_q && (sw_clr_repeat_active_flag || i_far_branch)) begin
                act0_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Level 1 loop state
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt1_q   <= {CW{1'b0}};
            save1_q  <= {CW{1'b0}};
            start1_q <= {AW{1'b0}};
            end1_q   <= {AW{1'b0}};
            act1_q   <= 1'b0;
        end else if (i_ce) begin
            if (wr_en && i_paddr == `LBR_OFS_SAVE1) save1_q <= i_pwdata[CW-1:0];
            if (wr_en && i_paddr == `LBR_OFS_CNT1 && !legacy_q) cnt1_q <= i_pwdata[CW-1:0];
            if (wr_en && i_paddr == `LBR_OFS_START1 && !legacy_q) start1_q <= i_pwdata[AW-1:0];
            if (wr_en && i_paddr == `LBR_OFS_END1 && !legacy_q) end1_q <= i_pwdata[AW-1:0];
            if (nest1) begin
                act1_q   <= 1'b1;
                cnt1_q   <= save1_q;
                start1_q <= i_ad_first_addr;
                end1_q   <= ad_end;
            end else if (end1_hit) begin
                if (cnt1_q != {CW{1'b0}}) begin
                    cnt1_q <= cnt1_q - {{(CW-1){1'b0}}, 1'b1};
                end else begin
                    act1_q <= 1'b0;
                end
            end else if (i_exit_branch || legacy_q) begin
                act1_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Mode, active flag and context capture
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            legacy_q   <= 1'b0;
            repeat_active_flag_q     <= 1'b0;
            flow_ctx_q <= 1'b0;
            fit_err_q  <= 1'b0;
        end else if (i_ce) begin
            if (wr_en && i_paddr == `LBR_OFS_CTRL) begin
                legacy_q <= i_pwdata[`LBR_CTRL_LEGACY];
                repeat_active_flag_q   <= i_pwdata[`LBR_CTRL_REPEAT_ACTIVE_FLAG];
            end
            if (i_far_branch) repeat_active_flag_q <= 1'b0;
            // End of level 0 in legacy mode clears flag
            if (legacy_q && end0_hit && cnt0_q == {CW{1'b0}}) repeat_active_flag_q <= 1'b0;
            if (legacy_q && enter0) repeat_active_flag_q <= 1'b1;
            if (i_int_ack) flow_ctx_q <= repeat_active_flag_q;
            else if (wr_en && i_paddr == `LBR_OFS_FLOWCTX) flow_ctx_q <= i_pwdata[0];
            // Sticky fit error, write one clears, set wins
            if (wr_en && i_paddr == `LBR_OFS_STATUS && i_pwdata[`LBR_ST_FITERR]) fit_err_q <= 1'b0;
            if (fit_bad) fit_err_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Fetch redirect at loop end
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_redirect      <= 1'b0;
            o_redirect_addr <= {AW{1'b0}};
        end else if (i_ce) begin
            o_redirect <= (end1_hit && cnt1_q != {CW{1'b0}}) ||
                          (end0_hit && cnt0_q != {CW{1'b0}});
            if (end1_hit) o_redirect_addr <= start1_q;
            else if (end0_hit) o_redirect_addr <= start0_q;
        end
    end

    // ----------------------------------------
    // Forward conditional branch timing
    // ----------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cond_q     <= 1'b0;
            cb_cnt_q   <= 2'h0;
            cb_cond_q  <= 1'b0;
            o_cb_done  <= 1'b0;
            o_cb_taken <= 1'b0;
        end else if (i_ce) begin
            if (i_cond_set) cond_q <= i_cond_val;
            o_cb_done <= 1'b0;
            if (cb_cnt_q == 2'h0) begin
                if (i_cb_req) begin
                    cb_cnt_q  <= `LBR_CB_CYCLES - 2'h1;
                    cb_cond_q <= cond_q;
                end
            end else begin
                cb_cnt_q <= cb_cnt_q - 2'h1;
                if (cb_cnt_q == 2'h1) begin
                    o_cb_done  <= 1'b1;
                    o_cb_taken <= cb_cond_q;
                end
            end
        end
    end

endmodule // lbr_loop_ctrl

// [lbr_loop_ctrl_assertions.sv]
// Port checker for the loop controller
`timescale 1ns/1ns
module lbr_loop_ctrl_checker (
    // Clock and reset
    input wire       i_ref_clk,
    input wire       i_rst_n,
    input wire       i_ce,
    // Register bus
    input wire       i_psel,
    input wire       i_penable,
    input wire [7:0] i_paddr,
    input wire       o_pready,
    input wire       o_pslverr,
    // Pipeline side
    input wire       i_ad_rpt,
    input wire       i_dc_valid,
    input wire       i_cb_req,
    input wire       i_int_ack,
    input wire       o_redirect,
    input wire       o_cb_done,
    input wire       o_cb_busy,
    input wire       o_loop_active,
    input wire       o_flow_ctx_flag
);
    default clocking dc @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n || !i_ce);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    ready_always_a: assert property (o_pready) else $error("pready low");
    unmapped_err_a: assert property (i_psel && i_penable && i_paddr > 8'h24 |-> o_pslverr)
        else $error("no error on unmapped access");
    mapped_ok_a: assert property (i_psel && i_penable && i_paddr <= 8'h24 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
        else $error("error on mapped access");
    branch_timing_a: assert property (i_cb_req && !o_cb_busy |=> o_cb_busy [*2] ##1 o_cb_done)
        else $error("branch not done in three cycles");
    branch_cause_a: assert property (o_cb_done |-> $past(i_cb_req, 3))
        else $error("branch done without request");
    redirect_pulse_a: assert property (o_redirect |=> !o_redirect)
        else $error("redirect longer than one cycle");
    redirect_cause_a: assert property (o_redirect |-> $past(i_dc_valid) && o_loop_active)
        else $error("redirect without decode in a loop");
    repeat_entry_a: assert property (i_ad_rpt |=> o_loop_active)
        else $error("loop not active after repeat");
    context_cause_a: assert property ($rose(o_flow_ctx_flag) |-> $past(i_int_ack) || $past(i_penable))
        else $error("context flag set without cause");
    cover property (o_redirect);
    cover property (o_cb_done);
    cover property (i_psel && i_penable && o_pslverr);
endmodule // lbr_loop_ctrl_checker

bind lbr_loop_ctrl lbr_loop_ctrl_checker chk_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ad_rpt(i_ad_rpt), .i_dc_valid(i_dc_valid), .i_cb_req(i_cb_req), .i_int_ack(i_int_ack),
    .o_redirect(o_redirect), .o_cb_done(o_cb_done), .o_cb_busy(o_cb_busy), .o_loop_active(o_loop_active),
    .o_flow_ctx_flag(o_flow_ctx_flag));

// [lbr_pipe_model.sv]
// Fetch and decode stage model feeding the loop controller
`timescale 1ns/1ns
module lbr_pipe_model #(
    parameter AW = 24
) (
    // Clock and fetch redirect
    input  wire          i_ref_clk,
    input  wire          i_redirect,
    input  wire [AW-1:0] i_redirect_addr,
    // Address and decode stages
    output reg           o_ad_rpt = 1'b0,
    output reg  [AW-1:0] o_ad_first_addr = {AW{1'b0}},
    output reg  [7:0]    o_ad_body_bytes = 8'h00,
    output reg  [3:0]    o_ad_last_size = 4'h0,
    output reg           o_dc_valid = 1'b0,
    output reg  [AW-1:0] o_dc_addr = {AW{1'b0}}
);
    // Address phase of one repeat instruction
    task rpt(input [AW-1:0] a, input [7:0] nb, input [3:0] ls);
        @(posedge i_ref_clk);
        o_ad_rpt        <= 1'b1;
        o_ad_first_addr <= a;
        o_ad_body_bytes <= nb;
        o_ad_last_size  <= ls;
        @(posedge i_ref_clk);
        o_ad_rpt        <= 1'b0;
        o_ad_first_addr <= ~a;
    endtask
    // Two or more single instructions, small body
    // No count or mode writes while a body runs
    task run(input [AW-1:0] a, input int n, input [3:0] sz, output int p);
        reg [AW-1:0] pc;
        int          k;
        pc = a;
        k  = 0;
        p  = 0;
        while (k < n) begin
            @(posedge i_ref_clk);
            o_dc_valid <= 1'b1;
            o_dc_addr  <= pc;
            pc = pc + sz;
            k++;
            if (k == n) begin
                p++;
                @(posedge i_ref_clk);
                o_dc_valid <= 1'b0;
                o_dc_addr  <= ~o_dc_addr;
                #1;
                if (i_redirect === 1'b1) begin
                    pc = i_redirect_addr;
                    k  = 0;
                end
            end
        end
    endtask
endmodule // lbr_pipe_model

// [lbr_loop_ctrl_bench.sv]
// Self-checking bench for the loop controller
`timescale 1ns/1ns
`include "lbr_loop_defines.vh"
module lbr_loop_ctrl_bench;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         psel = 1'b0, pen = 1'b0, pwr = 1'b0, es;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rdata;
    reg         cb_req = 1'b0, c_set = 1'b0, c_val = 1'b0, ce = 1'b1;
    reg  [2:0]  ev = 3'h0;
    wire        rpt, dcv, redir, done, taken, busy, act, leg, ctx, rdy, serr;
    wire [23:0] fa, dca, ra;
    wire [7:0]  nb;
    wire [3:0]  ls;
    wire [31:0] prd;
    int         bad_count = 0, cmp_count = 0, p;
    lbr_loop_ctrl uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr),
        .i_ad_rpt(rpt), .i_ad_first_addr(fa), .i_ad_body_bytes(nb), .i_ad_last_size(ls), .i_ad_last_par(1'b0),
        .i_dc_valid(dcv), .i_dc_addr(dca), .i_cb_req(cb_req), .i_cond_set(c_set), .i_cond_val(c_val),
        .i_exit_branch(ev[0]), .i_far_branch(ev[1]), .i_int_ack(ev[2]), .o_redirect(redir),
        .o_redirect_addr(ra), .o_cb_done(done), .o_cb_taken(taken), .o_cb_busy(busy),
        .o_loop_active(act), .o_legacy_mode(leg), .o_flow_ctx_flag(ctx));
    lbr_pipe_model pm (.i_ref_clk(clk), .i_redirect(redir), .i_redirect_addr(ra), .o_ad_rpt(rpt),
        .o_ad_first_addr(fa), .o_ad_body_bytes(nb), .o_ad_last_size(ls), .o_dc_valid(dcv), .o_dc_addr(dca));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input [31:0] g, input [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One bus transfer, held until pready is seen
    task apb(input bit wr, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rdata = prd;
        es = serr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
        // Let the write edge settle before outputs are looked at
        #1;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    // One-cycle exit, far branch or interrupt event
    task pulse(input [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_loop0;
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, es}, 32'h1);
        wr(`LBR_OFS_CNT0, 32'h3);
        pm.rpt(24'h004005, 8'h08, 4'h2);
        pm.run(24'h004005, 4, 4'h2, p);
        chk(p, 4);
        rd(`LBR_OFS_CNT0, 32'h0);
        rd(`LBR_OFS_START0, 32'h4005);
        rd(`LBR_OFS_END0, 32'h400B);
        chk(act, 0);
    endtask
    task t_nest;
        wr(`LBR_OFS_CNT0, 32'h5);
        wr(`LBR_OFS_SAVE1, 32'h2);
        pm.rpt(24'h001000, 8'h20, 4'h2);
        pm.rpt(24'h001004, 8'h06, 4'h3);
        rd(`LBR_OFS_CNT1, 32'h2);
        rd(`LBR_OFS_START1, 32'h1004);
        rd(`LBR_OFS_END1, 32'h1007);
        pm.run(24'h001004, 2, 4'h3, p);
        chk(p, 3);
        rd(`LBR_OFS_CNT1, 32'h0);
        rd(`LBR_OFS_SAVE1, 32'h2);
        pulse(3'h1);
        rd(`LBR_OFS_CNT0, 32'h5);
        chk(act, 0);
    endtask
    task t_branch(input bit v);
        @(posedge clk);
        c_set <= 1'b1;
        c_val <= v;
        @(posedge clk);
        c_set  <= 1'b0;
        cb_req <= 1'b1;
        @(posedge clk);
        cb_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(done, 1);
        chk(taken, v);
    endtask
    task t_legacy;
        wr(`LBR_OFS_CTRL, 32'h1);
        chk(leg, 1);
        wr(`LBR_OFS_CNT1, 32'h7);
        rd(`LBR_OFS_CNT1, 32'h0);
        wr(`LBR_OFS_CNT0, 32'h1);
        pm.rpt(24'h002001, 8'h08, 4'h2);
        pulse(3'h4);
        rd(`LBR_OFS_CTRL, 32'h3);
        pm.run(24'h002001, 4, 4'h2, p);
        chk(p, 2);
        rd(`LBR_OFS_CTRL, 32'h1);
        chk(ctx, 1);
        wr(`LBR_OFS_CNT0, 32'h9);
        pm.rpt(24'h002001, 8'h08, 4'h2);
        wr(`LBR_OFS_CTRL, 32'h1);
        chk(act, 0);
        pm.rpt(24'h002001, 8'h08, 4'h2);
        pulse(3'h2);
        rd(`LBR_OFS_CTRL, 32'h1);
    endtask
    // Misaligned full-size body flags a fit error
    task t_fit;
        wr(`LBR_OFS_CTRL, 32'h0);
        pm.rpt(24'h003001, 8'h80, 4'h2);
        rd(`LBR_OFS_STATUS, 32'h5);
        pulse(3'h1);
        wr(`LBR_OFS_STATUS, 32'h4);
        rd(`LBR_OFS_STATUS, 32'h0);
    endtask
    // Enable low freezes register writes
    task t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wr(`LBR_OFS_SAVE1, 32'h9);
        @(posedge clk);
        ce <= 1'b1;
        rd(`LBR_OFS_SAVE1, 32'h2);
    endtask
    // Verdict and end of run
    task end_sim;
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #10 clk = ~clk;
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_loop0();
        t_nest();
        t_branch(1'b1);
        t_branch(1'b0);
        t_legacy();
        t_fit();
        t_freeze();
        end_sim();
    end
endmodule // lbr_loop_ctrl_bench
